// file: rtl/pue_pkg.sv
package pue_pkg;
   localparam int          PUE_DATA_W       = 32;
   localparam int          PUE_ADDR_W       = 8;
   localparam int          PUE_PORTS        = 4;
   localparam int          PUE_PINS         = 8;
   localparam logic [7:0]  PUE_OFS_LOW      = 8'h04;
   localparam logic [31:0] PUE_RESET_LOW    = 32'h0010_0000;
   localparam int          PUE_GRP_A_LSB    = 0;
   localparam int          PUE_GRP_B_LSB    = 8;
   localparam int          PUE_GRP_C_LSB    = 16;
   localparam int          PUE_GRP_D_LSB    = 24;
   localparam logic [31:0] PUE_READ_UNMAPPED = 32'h0000_0000;

   typedef enum logic [1:0]
   {
      PUE_PIN_INPUT  = 2'h0,
      PUE_PIN_OUTPUT = 2'h1,
      PUE_PIN_HIZ    = 2'h2
   } pue_pin_mode_t;
endpackage

// file: rtl/pue_bank_if.sv
`timescale 1ns/1ns
interface pue_bank_if;
   logic [31:0] enable_bits;
   logic [31:0] input_mask;
   logic [31:0] pull_on;
   modport bank (input enable_bits, input input_mask, output pull_on);
   modport ctrl (output enable_bits, output input_mask, input pull_on);
endinterface

// file: rtl/pue_pin_gate.sv
`timescale 1ns/1ns
module pue_pin_gate
   import pue_pkg::*;
#(
   parameter int PORTS = PUE_PORTS,
   parameter int PINS  = PUE_PINS
)
(
   pue_bank_if.bank bank
);
   // Pull-up only where the pin is an input
   genvar g;
   for (g = 0; g < PORTS * PINS; g++)
   begin : g_pin
      assign bank.pull_on[g] = bank.enable_bits[g] & bank.input_mask[g];
   end
endmodule

// file: rtl/pue_pullup_enable_low.sv
// Operation
// [RQ1] Register sits at byte offset four
// [RQ2] Bits 31..24 pull group D pins 7..0
// [RQ3] Bits 23..16 pull group C pins 7..0
// [RQ4] Bits 15..8 group B, 7..0 group A
// [RQ5] One enables pull-up, zero disables it
// [RQ6] Enable ignored for outputs and Hi-Z
// [RQ7] Reset clears all but bit 20 set
// [RQ8] All bits read back last write
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
module pue_pullup_enable_low
   import pue_pkg::*;
(
   input  wire logic                          clock,
   input  wire logic                          rst,
   input  wire logic [pue_pkg::PUE_ADDR_W-1:0] addr,
   input  wire logic [pue_pkg::PUE_DATA_W-1:0] wdata,
   input  wire logic                          wr_en,
   input  wire logic                          rd_en,
   output logic      [pue_pkg::PUE_DATA_W-1:0] rdata,
   input  wire logic [63:0]                   pin_mode,
   output logic      [7:0]                    gpio_group_a_pull_on,
   output logic      [7:0]                    gpio_group_b_pull_on,
   output logic      [7:0]                    gpio_group_c_pull_on,
   output logic      [7:0]                    gpio_group_d_pull_on
);
   import pue_pkg::*;

   logic [31:0] pullup_enable_low_reg;
   logic [31:0] pullup_enable_low_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [31:0] input_mask;

   pue_bank_if bank_if ();

   function automatic logic hit_low(input logic [PUE_ADDR_W-1:0] a);
      hit_low = (a == PUE_OFS_LOW);
   endfunction

   // [RQ1] offset decode
   // [RQ8] write and read back
   always_comb
   begin
      pullup_enable_low_next = pullup_enable_low_reg;
      rdata_next             = PUE_READ_UNMAPPED;
      if (wr_en && hit_low(addr))
      begin
         pullup_enable_low_next = wdata;
      end
      if (rd_en && hit_low(addr))
      begin
         rdata_next = pullup_enable_low_reg;
      end
   end

   // [RQ7] reset pattern
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         pullup_enable_low_reg <= PUE_RESET_LOW;
         rdata_reg             <= PUE_READ_UNMAPPED;
      end
      else
      begin
         pullup_enable_low_reg <= pullup_enable_low_next;
         rdata_reg             <= rdata_next;
      end
   end

   assign rdata = rdata_reg;

   // [RQ6] input mask
   genvar p;
   for (p = 0; p < PUE_DATA_W; p++)
   begin : g_mask
      assign input_mask[p] = (pin_mode[2*p +: 2] == PUE_PIN_INPUT);
   end

   assign bank_if.enable_bits = pullup_enable_low_reg;
   assign bank_if.input_mask  = input_mask;

   // [RQ5] pull gating
   pue_pin_gate u_gate
   (
      .bank (bank_if.bank)
   );

   // [RQ2] group D field
   assign gpio_group_d_pull_on = bank_if.pull_on[PUE_GRP_D_LSB +: PUE_PINS];
   // [RQ3] group C field
   assign gpio_group_c_pull_on = bank_if.pull_on[PUE_GRP_C_LSB +: PUE_PINS];
   // [RQ4] groups B and A
   assign gpio_group_b_pull_on = bank_if.pull_on[PUE_GRP_B_LSB +: PUE_PINS];
   assign gpio_group_a_pull_on = bank_if.pull_on[PUE_GRP_A_LSB +: PUE_PINS];

   // [RQ8] write step
   sequence s_write_low;
      wr_en && addr == PUE_OFS_LOW;
   endsequence

   // [RQ8] read step
   sequence s_read_low;
      rd_en && addr == PUE_OFS_LOW;
   endsequence

   // [RQ8] no write step
   sequence s_no_write;
      !(wr_en && addr == PUE_OFS_LOW);
   endsequence

   // [RQ8] write lands
   a_write_stores: assert property (@(posedge clock) disable iff (rst) // [RQ8]
      s_write_low |=> pullup_enable_low_reg == $past(wdata))
      else $error("write not stored");

   // [RQ1] read returns register
   a_read_returns: assert property (@(posedge clock) disable iff (rst) // [RQ1]
      s_read_low |=> rdata == $past(pullup_enable_low_reg))
      else $error("read data wrong");

   // [RQ7] reset pattern
   a_reset_value: assert property (@(posedge clock) // [RQ7]
      rst |=> pullup_enable_low_reg == PUE_RESET_LOW)
      else $error("reset value wrong");

   // [RQ7] read data cleared
   a_reset_rdata: assert property (@(posedge clock) // [RQ7]
      rst |=> rdata == PUE_READ_UNMAPPED)
      else $error("read data not cleared");

   // [RQ2] group D field
   a_group_d_map: assert property (@(posedge clock) disable iff (rst) // [RQ2]
      gpio_group_d_pull_on == (pullup_enable_low_reg[PUE_GRP_D_LSB +: PUE_PINS]
         & input_mask[PUE_GRP_D_LSB +: PUE_PINS]))
      else $error("group D map wrong");

   // [RQ3] group C field
   a_group_c_map: assert property (@(posedge clock) disable iff (rst) // [RQ3]
      gpio_group_c_pull_on == (pullup_enable_low_reg[PUE_GRP_C_LSB +: PUE_PINS]
         & input_mask[PUE_GRP_C_LSB +: PUE_PINS]))
      else $error("group C map wrong");

   // [RQ4] groups B and A
   a_group_ba_map: assert property (@(posedge clock) disable iff (rst) // [RQ4]
      {gpio_group_b_pull_on, gpio_group_a_pull_on}
         == (pullup_enable_low_reg[PUE_GRP_A_LSB +: 2*PUE_PINS]
         & input_mask[PUE_GRP_A_LSB +: 2*PUE_PINS]))
      else $error("group B or A map wrong");

   // [RQ6] non-input pin off
   a_output_off: assert property (@(posedge clock) disable iff (rst) // [RQ6]
      pin_mode[1:0] != PUE_PIN_INPUT |-> !gpio_group_a_pull_on[0])
      else $error("pull on non-input pin");

   // [RQ5] enable reaches pin
   a_enable_on: assert property (@(posedge clock) disable iff (rst) // [RQ5]
      pin_mode[41:40] == PUE_PIN_INPUT && pullup_enable_low_reg[20]
         |-> gpio_group_c_pull_on[4])
      else $error("pull-up not enabled");

   // [RQ1] unmapped read zero
   a_unmapped_zero: assert property (@(posedge clock) disable iff (rst) // [RQ1]
      rd_en && addr != PUE_OFS_LOW |=> rdata == PUE_READ_UNMAPPED)
      else $error("unmapped read nonzero");

   // [RQ1] unmapped write ignored
   a_unmapped_write: assert property (@(posedge clock) disable iff (rst) // [RQ1]
      wr_en && addr != PUE_OFS_LOW |=> $stable(pullup_enable_low_reg))
      else $error("unmapped write stored");

   // [RQ8] register holds value
   a_hold_no_write: assert property (@(posedge clock) disable iff (rst) // [RQ8]
      s_no_write |=> $stable(pullup_enable_low_reg))
      else $error("register changed without write");

   // [RQ8] read data idle
   a_read_idle: assert property (@(posedge clock) disable iff (rst) // [RQ8]
      !rd_en |=> rdata == PUE_READ_UNMAPPED)
      else $error("read data not idle");

   // [RQ8] write then read back
   a_write_read_back: assert property (@(posedge clock) disable iff (rst) // [RQ8]
      s_write_low ##1 !wr_en ##1 s_read_low |=> rdata == $past(wdata, 3))
      else $error("read back wrong");

   // [RQ5] per-pin gating checks
   genvar q;
   for (q = 0; q < PUE_DATA_W; q++)
   begin : g_pin_chk
      // [RQ5] enabled input pulls
      a_pin_on: assert property (@(posedge clock) disable iff (rst) // [RQ5]
         pullup_enable_low_reg[q] && pin_mode[2*q +: 2] == PUE_PIN_INPUT
            |-> bank_if.pull_on[q])
         else $error("pin pull-up missing");

      // [RQ6] non-input never pulls
      a_pin_off: assert property (@(posedge clock) disable iff (rst) // [RQ6]
         pin_mode[2*q +: 2] != PUE_PIN_INPUT |-> !bank_if.pull_on[q])
         else $error("pin pulled while not input");

      // [RQ5] zero bit never pulls
      a_pin_zero: assert property (@(posedge clock) disable iff (rst) // [RQ5]
         !pullup_enable_low_reg[q] |-> !bank_if.pull_on[q])
         else $error("pin pulled while disabled");
   end
endmodule

// file: testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   import pue_pkg::*;
   logic        clock;
   logic        rst;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic        wr_en;
   logic        rd_en;
   logic [31:0] rdata;
   logic [63:0] pin_mode;
   logic [7:0]  pa, pb, pc, pd;
   logic [31:0] mdl;
   logic [31:0] d;
   int          n_fail;
   int          checks;
   pue_pullup_enable_low u_pue_pullup_enable_low (.clock(clock), .rst(rst), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pin_mode(pin_mode),
      .gpio_group_a_pull_on(pa), .gpio_group_b_pull_on(pb),
      .gpio_group_c_pull_on(pc), .gpio_group_d_pull_on(pd));
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic give_verdict;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock);
      addr <= a; wdata <= v; wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
      if (a == 8'h04) mdl = v;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      addr <= a; rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1 cmp("rdata", (a == 8'h04) ? mdl : 32'h0, rdata);
      @(posedge clock);
      #1 cmp("rdata_idle", 32'h0, rdata);
   endtask
   task automatic chk_pull;
      logic [31:0] e;
      for (int p = 0; p < 32; p++) e[p] = mdl[p] && (pin_mode[2*p +: 2] == 2'h0);
      cmp("pull_a", {24'h0, e[7:0]}, {24'h0, pa});
      cmp("pull_b", {24'h0, e[15:8]}, {24'h0, pb});
      cmp("pull_c", {24'h0, e[23:16]}, {24'h0, pc});
      cmp("pull_d", {24'h0, e[31:24]}, {24'h0, pd});
   endtask
   initial
   begin
      repeat (100000) @(posedge clock);
      n_fail++;
      give_verdict;
   end
   initial
   begin
      rst = 1'b1; addr = 8'h0; wdata = 32'h0; wr_en = 1'b0; rd_en = 1'b0;
      pin_mode = 64'h0; mdl = 32'h0010_0000; n_fail = 0; checks = 0;
      void'($urandom(32'hE6F1BA8B));
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      rd(8'h04);
      chk_pull;
      rd(8'h00);
      wr(8'h08, 32'hFFFF_FFFF);
      rd(8'h04);
      for (int i = 0; i < 24; i++)
      begin
         d = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0 : $urandom;
         pin_mode <= (i < 2) ? 64'h0 : {$urandom, $urandom};
         wr(8'h04, d);
         rd(8'h04);
         chk_pull;
      end
      @(posedge clock);
      rst <= 1'b1;
      @(posedge clock);
      rst <= 1'b0;
      mdl = 32'h0010_0000;
      rd(8'h04);
      chk_pull;
      give_verdict;
   end
endmodule
